// ### rtl/rcs_pkg.sv
`default_nettype none
package rcs_pkg;
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned XTAL_HZ      = 32768;
    localparam int unsigned SEC_DIV      = XTAL_HZ;
    localparam int unsigned RST_DELAY_MS = 250;
    localparam int unsigned WD0_MS       = 250;
    localparam int unsigned WD1_MS       = 750;
    localparam int unsigned WD2_MS       = 1750;
    localparam int unsigned OSC_FAIL_US  = 100;
    localparam int unsigned RST_CYC      = CLK_HZ / 1000 * RST_DELAY_MS;
    localparam int unsigned WD0_CYC      = CLK_HZ / 1000 * WD0_MS;
    localparam int unsigned WD1_CYC      = CLK_HZ / 1000 * WD1_MS;
    localparam int unsigned WD2_CYC      = CLK_HZ / 1000 * WD2_MS;
    localparam int unsigned OSC_FAIL_CYC = CLK_HZ / 1_000_000 * OSC_FAIL_US;
    localparam int          CNT_W        = 26;

    localparam logic [7:0] OFS_TIME    = 8'h00;
    localparam logic [7:0] OFS_COMMIT  = 8'h20;
    localparam logic [7:0] OFS_STATUS  = 8'h24;
    localparam logic [7:0] OFS_CONTROL = 8'h28;
    localparam logic [7:0] OFS_KICK    = 8'h2c;
    localparam logic [7:0] OFS_ALARM   = 8'h40;

    localparam int ST_RTCF = 0;
    localparam int ST_WEL  = 1;
    localparam int ST_OSCF = 4;
    localparam int ST_AL0  = 5;
    localparam int ST_AL1  = 6;
    localparam int ST_BAT  = 7;
    localparam int CMT_GO  = 0;
    localparam int ALM_EN  = 7;
    localparam int HR_MIL  = 7;
    localparam int HR_PM   = 5;

    localparam logic [2:0] THR_MAX = 3'h4;
    localparam logic [2:0] DOW_MAX = 3'h6;

    typedef enum logic [1:0] {FS_OFF = 2'h0, FS_1HZ = 2'h1, FS_4K = 2'h2, FS_32K = 2'h3} rcs_fsel_t;
    typedef enum logic [1:0] {SV_HOLD = 2'h0, SV_RUN = 2'h1, SV_BAT = 2'h3} rcs_sv_t;

    typedef struct packed {
        logic       busbat;
        logic [1:0] wd_sel;
        logic [2:0] thr_sel;
        logic       repeat_en;
        logic       irq_en;
        rcs_fsel_t  fsel;
    } rcs_ctl_t;

    typedef struct packed {
        logic [7:0] cent;
        logic [7:0] dow;
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rcs_time_t;

    localparam rcs_ctl_t   CTL_RST  = '0;
    localparam rcs_time_t  TIME_RST = '{cent: 8'h20, dow: 8'h00, year: 8'h00, month: 8'h01,
                                        date: 8'h01, hour: 8'h12, min: 8'h00, sec: 8'h00};
    localparam logic [7:0] ALM_RST  = 8'h00;
endpackage
`default_nettype wire

// ### rtl/rcs_calendar.sv
`default_nettype none
module rcs_calendar (
    input  wire logic               clk_in,
    input  wire logic               reset_n_in,
    input  wire logic               tick_in,
    input  wire logic               run_in,
    input  wire logic               load_in,
    input  wire rcs_pkg::rcs_time_t load_val_in,
    output var  rcs_pkg::rcs_time_t time_out
);
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    // one century only: every fourth year, 00 included, is leap
    function automatic logic leap(input logic [7:0] y);
        return y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02:                      return leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default:                    return 8'h31;
        endcase
    endfunction

    wire logic [7:0] h24 = bcd_inc({2'h0, time_out.hour[5:0]});
    wire logic [7:0] h12 = bcd_inc({3'h0, time_out.hour[4:0]});
    rcs_pkg::rcs_time_t nxt;
    logic               day_c;

    always_comb begin
        nxt   = time_out;
        day_c = 1'b0;
        if (time_out.sec != 8'h59) begin
            nxt.sec = bcd_inc(time_out.sec);
        end else begin
            nxt.sec = 8'h00;
            if (time_out.min != 8'h59) begin
                nxt.min = bcd_inc(time_out.min);
            end else begin
                nxt.min = 8'h00;
                if (time_out.hour[rcs_pkg::HR_MIL]) begin
                    if (time_out.hour[5:0] == 6'h23) begin
                        nxt.hour[5:0] = 6'h00;
                        day_c         = 1'b1;
                    end else begin
                        nxt.hour[5:0] = h24[5:0];
                    end
                end else if (time_out.hour[4:0] == 5'h12) begin
                    nxt.hour[4:0] = 5'h01;
                end else if (time_out.hour[4:0] == 5'h11) begin
                    nxt.hour[4:0]             = 5'h12;
                    nxt.hour[rcs_pkg::HR_PM]  = ~time_out.hour[rcs_pkg::HR_PM];
                    day_c                     = time_out.hour[rcs_pkg::HR_PM];
                end else begin
                    nxt.hour[4:0] = h12[4:0];
                end
            end
        end
        if (day_c) begin
            nxt.dow = (time_out.dow[2:0] == rcs_pkg::DOW_MAX) ? 8'h00 :
                      {5'h00, time_out.dow[2:0] + 3'h1};
            if (time_out.date != last_date(time_out.month, time_out.year)) begin
                nxt.date = bcd_inc(time_out.date);
            end else begin
                nxt.date = 8'h01;
                if (time_out.month != 8'h12) begin
                    nxt.month = bcd_inc(time_out.month);
                end else begin
                    nxt.month = 8'h01;
                    nxt.year  = (time_out.year == 8'h99) ? 8'h00 : bcd_inc(time_out.year);
                    nxt.cent  = (time_out.year == 8'h99) ? bcd_inc(time_out.cent) : time_out.cent;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            time_out <= rcs_pkg::TIME_RST;
        end else if (load_in) begin
            time_out <= load_val_in;
        end else if (tick_in && run_in) begin
            time_out <= nxt;
        end
    end
endmodule
`default_nettype wire

// ### rtl/rcs_top.sv
// Contract
// - count seconds to years from crystal
// - leap years handled, valid through 2099
// - short months roll over; 12/24 hour select
// - after total loss, stopped until byte written
// - clock read latches time, served from latch
// - alarms compare live time during reads
// - bytes staged, loaded only on valid commit
// - invalid write discards staged bytes
// - new time appears at next second tick
// - counting continues during time writes
// - two alarms match programmable time fields
// - alarm flags pollable, optional interrupt pin
// - repeat mode gives recurring alarm events
// - pin selects off, 1Hz, 4096Hz, 32768Hz
// - interrupt mode pulls pin low, open drain
// - reset released 250 ms after supply good
// - reset on low supply, five thresholds
// - watchdog off or 0.25/0.75/1.75 s
// - bus ignored during reset unless enabled
// - watchdog disabled on backup supply
// - battery-mode reset holds until main supply
// - time registers are BCD within ranges
// - status read clears only earlier flags
// - weekday counts 0 to 6, default 0
`default_nettype none
module rcs_top #(
    parameter int unsigned RST_CYC = rcs_pkg::RST_CYC,
    parameter int unsigned WD0_CYC = rcs_pkg::WD0_CYC,
    parameter int unsigned WD1_CYC = rcs_pkg::WD1_CYC,
    parameter int unsigned WD2_CYC = rcs_pkg::WD2_CYC
) (
    input  wire logic        CLK_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [7:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output var  logic [31:0] WB_DAT_OUT,
    output var  logic        WB_ACK_OUT,
    input  wire logic        CRYSTAL_AMP_INPUT_IN,
    output var  logic        CRYSTAL_AMP_OUTPUT_OUT,
    input  wire logic [4:0]  SUPPLY_ABOVE_IN,
    input  wire logic        BATTERY_MODE_IN,
    output var  logic        ALARM_IRQ_FREQ_OUT_PIN_OUT,
    output var  logic        ALARM_IRQ_FREQ_OUT_PIN_OE_OUT,
    output var  logic        RESET_N_PIN_OUT,
    output var  logic        RESET_N_PIN_OE_OUT
);
    localparam int         CW      = rcs_pkg::CNT_W;
    localparam logic [11:0] OSC_LIM = 12'(rcs_pkg::OSC_FAIL_CYC);
    localparam logic [14:0] DIV_TOP = 15'(rcs_pkg::SEC_DIV - 1);

    function automatic logic is_at(input logic [7:0] a, input logic [7:0] o);
        return a[7:2] == o[7:2];
    endfunction

    function automatic logic [CW-1:0] wd_lim(input logic [1:0] s);
        case (s)
            2'h1:    return CW'(WD0_CYC - 1);
            2'h2:    return CW'(WD1_CYC - 1);
            default: return CW'(WD2_CYC - 1);
        endcase
    endfunction

    // pin synchronisers
    logic        xs1_q;
    logic        xs2_q;
    logic        xs3_q;
    logic [4:0]  sup1_q;
    logic [4:0]  sup2_q;
    logic        bat1_q;
    logic        bat2_q;

    logic [14:0] div_q;
    logic        tick_d_q;
    logic [11:0] osc_q;
    logic        oscf_q;

    logic        ack_q;
    rcs_pkg::rcs_ctl_t ctl_q;
    logic        wel_q;
    logic        rtcf_q;
    logic [63:0] stage_q;
    logic [7:0]  mask_q;
    logic        pending_q;
    logic [63:0] snap_q;
    logic [7:0]  alm_q [0:11];
    logic [1:0]  armed_q;
    logic [1:0]  flag_q;

    rcs_pkg::rcs_sv_t sv_q;
    rcs_pkg::rcs_sv_t sv_d;
    logic [CW-1:0] por_q;
    logic [CW-1:0] wd_q;

    rcs_pkg::rcs_time_t live;
    logic [63:0] merged;
    logic [7:0]  status_v;
    logic [1:0]  match;

    // rising crystal edges become one-cycle enables
    wire logic xtal_en  = xs2_q & ~xs3_q;
    wire logic sec_tick = xtal_en & (div_q == DIV_TOP);
    wire logic [63:0] live_v = live;

    // register bus decode
    wire logic       bus_ok  = (sv_q == rcs_pkg::SV_RUN) | ctl_q.busbat;
    wire logic       req     = WB_CYC_IN & WB_STB_IN & ~ack_q;
    wire logic       wr      = req & WB_WE_IN & bus_ok;
    wire logic       rd      = req & ~WB_WE_IN & bus_ok;
    wire logic       lane0   = WB_SEL_IN[0];
    wire logic       hit_tm  = WB_ADR_IN[7:5] == rcs_pkg::OFS_TIME[7:5];
    wire logic [2:0] tidx    = WB_ADR_IN[4:2];
    wire logic       hit_al  = (WB_ADR_IN[7:6] == rcs_pkg::OFS_ALARM[7:6]) && (tidx < 3'h6);
    wire logic [3:0] aidx    = WB_ADR_IN[5] ? ({1'b0, tidx} + 4'h6) : {1'b0, tidx};
    wire logic       wr_tm   = wr & hit_tm & lane0;
    wire logic       wr_cmt  = wr & is_at(WB_ADR_IN, rcs_pkg::OFS_COMMIT) & lane0;
    wire logic       wr_st   = wr & is_at(WB_ADR_IN, rcs_pkg::OFS_STATUS) & lane0;
    wire logic       wr_ctl  = wr & is_at(WB_ADR_IN, rcs_pkg::OFS_CONTROL);
    wire logic       kick    = wr & is_at(WB_ADR_IN, rcs_pkg::OFS_KICK);
    wire logic       wr_al   = wr & hit_al & lane0;
    wire logic       rd_st   = rd & is_at(WB_ADR_IN, rcs_pkg::OFS_STATUS);
    wire logic       rd_snap = rd & hit_tm & (tidx == 3'h0);
    wire logic       cmt_ok  = WB_DAT_IN[rcs_pkg::CMT_GO] & wel_q & (|mask_q);

    // the first time word returns live data and freezes the rest
    wire logic [7:0] tm_byte = (tidx == 3'h0) ? live_v[7:0] : snap_q[{tidx, 3'h0} +: 8];
    wire logic [31:0] rd_data =
        !bus_ok                                       ? 32'h0 :
        hit_tm                                        ? {24'h0, tm_byte} :
        is_at(WB_ADR_IN, rcs_pkg::OFS_COMMIT)         ? {23'h0, mask_q, pending_q} :
        is_at(WB_ADR_IN, rcs_pkg::OFS_STATUS)         ? {24'h0, status_v} :
        is_at(WB_ADR_IN, rcs_pkg::OFS_CONTROL)        ? {22'h0, ctl_q} :
        hit_al                                        ? {24'h0, alm_q[aidx]} :
        32'h0;

    // supervisor and watchdog
    wire logic [2:0] thr    = (ctl_q.thr_sel > rcs_pkg::THR_MAX) ? rcs_pkg::THR_MAX : ctl_q.thr_sel;
    wire logic       sup_ok = sup2_q[thr];
    wire logic       wd_run = (sv_q == rcs_pkg::SV_RUN) & (ctl_q.wd_sel != 2'h0) & ~bat2_q;
    wire logic       wd_exp = wd_run & (wd_q == wd_lim(ctl_q.wd_sel));

    // output pin source
    wire logic fr_lvl = (ctl_q.fsel == rcs_pkg::FS_1HZ) ? div_q[14] :
                        (ctl_q.fsel == rcs_pkg::FS_4K)  ? div_q[2]  : xs2_q;
    wire logic irq_drv = (ctl_q.fsel == rcs_pkg::FS_OFF) ? (ctl_q.irq_en & (|flag_q)) : ~fr_lvl;

    always_comb begin
        status_v                  = 8'h00;
        status_v[rcs_pkg::ST_BAT]  = bat2_q;
        status_v[rcs_pkg::ST_AL1]  = flag_q[1];
        status_v[rcs_pkg::ST_AL0]  = flag_q[0];
        status_v[rcs_pkg::ST_OSCF] = oscf_q;
        status_v[rcs_pkg::ST_WEL]  = wel_q;
        status_v[rcs_pkg::ST_RTCF] = rtcf_q;
    end

    // unwritten bytes keep the running value
    for (genvar g = 0; g < 8; g++) begin : g_merge
        assign merged[g*8 +: 8] = mask_q[g] ? stage_q[g*8 +: 8] : live_v[g*8 +: 8];
    end

    for (genvar g = 0; g < 2; g++) begin : g_alm
        logic [5:0] en;
        logic [5:0] ok;
        for (genvar f = 0; f < 6; f++) begin : g_fld
            localparam int LB = (f == 5) ? 6 : f;
            assign en[f] = alm_q[g*6+f][rcs_pkg::ALM_EN];
            assign ok[f] = ~en[f] | (alm_q[g*6+f][6:0] == live_v[LB*8 +: 7]);
        end
        assign match[g] = (|en) & (&ok);
    end

    wire logic [1:0] evt = {2{tick_d_q}} & armed_q & match;

    always_comb begin
        sv_d = sv_q;
        case (sv_q)
            rcs_pkg::SV_HOLD: begin
                // backup supply locks the reset until main power returns
                if (bat2_q) begin
                    sv_d = rcs_pkg::SV_BAT;
                end else if (sup_ok && por_q == CW'(RST_CYC - 1)) begin
                    sv_d = rcs_pkg::SV_RUN;
                end
            end
            rcs_pkg::SV_RUN: begin
                if (!sup_ok) begin
                    sv_d = bat2_q ? rcs_pkg::SV_BAT : rcs_pkg::SV_HOLD;
                end else if (wd_exp) begin
                    sv_d = rcs_pkg::SV_HOLD;
                end
            end
            rcs_pkg::SV_BAT: begin
                if (!bat2_q) begin
                    sv_d = rcs_pkg::SV_HOLD;
                end
            end
            default: begin
                sv_d = rcs_pkg::SV_HOLD;
            end
        endcase
    end

    rcs_calendar u_cal (
        .clk_in      (CLK_IN),
        .reset_n_in  (RESET_N_IN),
        .tick_in     (sec_tick & ~pending_q),
        .run_in      (~rtcf_q),
        .load_in     (sec_tick & pending_q),
        .load_val_in (rcs_pkg::rcs_time_t'(merged)),
        .time_out    (live)
    );

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            xs1_q  <= 1'b0;
            xs2_q  <= 1'b0;
            xs3_q  <= 1'b0;
            sup1_q <= 5'h00;
            sup2_q <= 5'h00;
            bat1_q <= 1'b0;
            bat2_q <= 1'b0;
        end else begin
            xs1_q  <= CRYSTAL_AMP_INPUT_IN;
            xs2_q  <= xs1_q;
            xs3_q  <= xs2_q;
            sup1_q <= SUPPLY_ABOVE_IN;
            sup2_q <= sup1_q;
            bat1_q <= BATTERY_MODE_IN;
            bat2_q <= bat1_q;
        end
    end

    // divider runs free so a commit waits for a real second boundary
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            div_q    <= 15'h0000;
            tick_d_q <= 1'b0;
            osc_q    <= 12'h000;
            oscf_q   <= 1'b0;
            CRYSTAL_AMP_OUTPUT_OUT <= 1'b1;
        end else begin
            div_q    <= xtal_en ? div_q + 15'h0001 : div_q;
            tick_d_q <= sec_tick;
            osc_q    <= xtal_en ? 12'h000 : ((osc_q == OSC_LIM) ? osc_q : osc_q + 12'h001);
            oscf_q   <= osc_q == OSC_LIM;
            CRYSTAL_AMP_OUTPUT_OUT <= ~xs2_q;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ack_q      <= 1'b0;
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h0;
        end else begin
            ack_q      <= req;
            WB_ACK_OUT <= req;
            WB_DAT_OUT <= (req & ~WB_WE_IN) ? rd_data : 32'h0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ctl_q  <= rcs_pkg::CTL_RST;
            wel_q  <= 1'b0;
            rtcf_q <= 1'b1;
            snap_q <= 64'h0;
        end else begin
            if (wr_ctl) begin
                ctl_q <= rcs_pkg::rcs_ctl_t'({WB_SEL_IN[1] ? WB_DAT_IN[9:8] : ctl_q[9:8],
                                              lane0 ? WB_DAT_IN[7:0] : ctl_q[7:0]});
            end
            if (wr_st) begin
                wel_q <= WB_DAT_IN[rcs_pkg::ST_WEL];
            end
            if (wr_tm) begin
                rtcf_q <= 1'b0;
            end
            if (rd_snap) begin
                snap_q <= live_v;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            stage_q   <= 64'h0;
            mask_q    <= 8'h00;
            pending_q <= 1'b0;
        end else begin
            if (pending_q && sec_tick) begin
                pending_q <= 1'b0;
                mask_q    <= 8'h00;
            end
            if (wr_tm) begin
                stage_q[{tidx, 3'h0} +: 8] <= WB_DAT_IN[7:0];
                mask_q[tidx]               <= 1'b1;
            end
            if (wr_cmt && cmt_ok) begin
                pending_q <= 1'b1;
            end else if (wr_cmt) begin
                mask_q <= 8'h00;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            for (int i = 0; i < 12; i++) begin
                alm_q[i] <= rcs_pkg::ALM_RST;
            end
            armed_q <= 2'h0;
            flag_q  <= 2'h0;
        end else begin
            if (wr_al) begin
                alm_q[aidx] <= WB_DAT_IN[7:0];
            end
            for (int a = 0; a < 2; a++) begin
                if (wr_al && WB_ADR_IN[5] == a[0]) begin
                    armed_q[a] <= 1'b1;
                end else if (evt[a] && !ctl_q.repeat_en) begin
                    armed_q[a] <= 1'b0;
                end
            end
            // an event in the clearing cycle survives
            flag_q <= rd_st ? evt : (flag_q | evt);
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            sv_q               <= rcs_pkg::SV_HOLD;
            por_q              <= '0;
            wd_q               <= '0;
            RESET_N_PIN_OUT    <= 1'b0;
            RESET_N_PIN_OE_OUT <= 1'b1;
            ALARM_IRQ_FREQ_OUT_PIN_OUT    <= 1'b1;
            ALARM_IRQ_FREQ_OUT_PIN_OE_OUT <= 1'b0;
        end else begin
            sv_q  <= sv_d;
            por_q <= (sv_q == rcs_pkg::SV_HOLD && sv_d == rcs_pkg::SV_HOLD && sup_ok) ?
                     por_q + 1'b1 : '0;
            wd_q  <= (!wd_run || kick || wd_exp) ? '0 : wd_q + 1'b1;
            RESET_N_PIN_OUT    <= sv_d == rcs_pkg::SV_RUN;
            RESET_N_PIN_OE_OUT <= sv_d != rcs_pkg::SV_RUN;
            ALARM_IRQ_FREQ_OUT_PIN_OUT    <= ~irq_drv;
            ALARM_IRQ_FREQ_OUT_PIN_OE_OUT <= irq_drv;
        end
    end
endmodule
`default_nettype wire

// ### testbench/rcs_top_properties.sv
`default_nettype none
module rcs_top_properties #(
    parameter int unsigned RST_CYC = 50
) (
    input wire logic        CLK_IN,
    input wire logic        RESET_N_IN,
    input wire logic        WB_CYC_IN,
    input wire logic        WB_STB_IN,
    input wire logic        WB_ACK_OUT,
    input wire logic [4:0]  SUPPLY_ABOVE_IN,
    input wire logic        BATTERY_MODE_IN,
    input wire logic        ALARM_IRQ_FREQ_OUT_PIN_OUT,
    input wire logic        ALARM_IRQ_FREQ_OUT_PIN_OE_OUT,
    input wire logic        RESET_N_PIN_OUT,
    input wire logic        RESET_N_PIN_OE_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    logic [31:0] good_q;
    // bit 0 is the lowest level, so any selected threshold implies it
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            good_q <= 32'h0;
        end else begin
            good_q <= SUPPLY_ABOVE_IN[0] ? good_q + 32'h1 : 32'h0;
        end
    end
    ack_one_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack too long");
    ack_answer_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT) else $error("no ack");
    ack_cause_a: assert property (WB_ACK_OUT |-> $past(WB_STB_IN)) else $error("stray ack");
    irq_drain_a: assert property (ALARM_IRQ_FREQ_OUT_PIN_OUT == !ALARM_IRQ_FREQ_OUT_PIN_OE_OUT) else $error("irq pin");
    rst_drain_a: assert property (RESET_N_PIN_OE_OUT |-> !RESET_N_PIN_OUT) else $error("reset pin");
    rst_release_a: assert property ($fell(RESET_N_PIN_OE_OUT) |-> good_q >= RST_CYC) else $error("early release");
    rst_low_a: assert property ((SUPPLY_ABOVE_IN == 5'h00) [*4] |-> ##[0:2] RESET_N_PIN_OE_OUT) else $error("no reset");
    bat_hold_a: assert property (BATTERY_MODE_IN [*4] ##0 RESET_N_PIN_OE_OUT |=> RESET_N_PIN_OE_OUT) else $error("bat");
    cover property ($fell(RESET_N_PIN_OE_OUT));
    cover property ($rose(ALARM_IRQ_FREQ_OUT_PIN_OE_OUT));
    cover property (BATTERY_MODE_IN && RESET_N_PIN_OE_OUT);
endmodule
bind rcs_top rcs_top_properties #(.RST_CYC(RST_CYC)) u_props (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
    .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT), .SUPPLY_ABOVE_IN(SUPPLY_ABOVE_IN),
    .BATTERY_MODE_IN(BATTERY_MODE_IN), .ALARM_IRQ_FREQ_OUT_PIN_OUT(ALARM_IRQ_FREQ_OUT_PIN_OUT),
    .ALARM_IRQ_FREQ_OUT_PIN_OE_OUT(ALARM_IRQ_FREQ_OUT_PIN_OE_OUT), .RESET_N_PIN_OUT(RESET_N_PIN_OUT),
    .RESET_N_PIN_OE_OUT(RESET_N_PIN_OE_OUT));
`default_nettype wire

// ### testbench/rcs_host_model.sv
`default_nettype none
module rcs_host_model (
    input  wire logic        clk_in,
    input  wire logic        ack_in,
    input  wire logic [31:0] dat_in,
    output var  logic        cyc_out,
    output var  logic        we_out,
    output var  logic [7:0]  adr_out,
    output var  logic [31:0] dat_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cyc_out = 1'b0;
        we_out = 1'b0;
        adr_out = 8'h00;
        dat_out = 32'h0;
    end
    // request held until ack seen at an edge, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        cyc_out <= 1'b1;
        we_out <= w;
        adr_out <= a;
        dat_out <= d;
        do @(posedge clk_in); while (ack_in !== 1'b1);
        r = dat_in;
        cyc_out <= 1'b0;
        dat_out <= ~d;
        @(posedge clk_in);
    endtask
    task automatic write_time(input rcs_pkg::rcs_time_t t);
        logic [31:0] r;
        for (int i = 0; i < 8; i++) xfer(1'b1, rcs_pkg::OFS_TIME + 8'(4 * i), {24'h0, t[8*i +: 8]}, r);
    endtask
endmodule
`default_nettype wire

// ### testbench/rcs_top_tb_top.sv
`default_nettype none
module rcs_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        bat = 1'b0;
    logic [2:0]  xc = 3'h0;
    logic [4:0]  sup = 5'h1f;
    logic        cyc, we, ack, irq_oe, rst_oe, p;
    logic [7:0]  adr, s;
    logic [31:0] wdat, rdat, rd;
    integer      seed = 90115;
    int          num_errors = 0;
    int          num_checks = 0;
    int          c;
    int          wd_t[4] = '{0, 40, 80, 120};
    int          fq_t[4] = '{0, 0, 16, 128};
    rcs_pkg::rcs_time_t tm;
    always #25 clk = ~clk;
    // crystal scaled to clk/8 so the divider taps show in a short run
    always @(posedge clk) xc <= xc + 3'h1;
    rcs_host_model u_host (.clk_in(clk), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc), .we_out(we), .adr_out(adr),
        .dat_out(wdat));
    rcs_top #(.RST_CYC(50), .WD0_CYC(40), .WD1_CYC(80), .WD2_CYC(120)) uut (.CLK_IN(clk), .RESET_N_IN(rst_n),
        .WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .CRYSTAL_AMP_INPUT_IN(xc[2]), .CRYSTAL_AMP_OUTPUT_OUT(),
        .SUPPLY_ABOVE_IN(sup), .BATTERY_MODE_IN(bat), .ALARM_IRQ_FREQ_OUT_PIN_OUT(),
        .ALARM_IRQ_FREQ_OUT_PIN_OE_OUT(irq_oe), .RESET_N_PIN_OUT(), .RESET_N_PIN_OE_OUT(rst_oe));
    function automatic logic [7:0] bcd(input int v);
        return 8'(v / 10 * 16 + v % 10);
    endfunction
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        u_host.xfer(1'b0, a, 32'h0, rd);
        check_val(rd, e);
    endtask
    task automatic wait_oe(input logic v, output int n);
        n = 0;
        while (rst_oe !== v && n < 2000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(rcs_pkg::OFS_STATUS, 32'h0);
        wait_oe(1'b0, c);
        check_val(c >= 40 && c <= 56, 32'h1);
        rd_chk(rcs_pkg::OFS_STATUS, 32'h1);
        for (int i = 0; i < 8; i++) rd_chk(8'(4 * i), 32'(rcs_pkg::TIME_RST[8*i +: 8]));
        s = bcd($unsigned($random(seed)) % 59 + 1);
        tm = '{8'h20, 8'h03, 8'h24, 8'h06, 8'h15, 8'h80, 8'h00, s};
        u_host.write_time(tm);
        rd_chk(rcs_pkg::OFS_COMMIT, 32'h1fe);
        rd_chk(rcs_pkg::OFS_STATUS, 32'h0);
        wr(rcs_pkg::OFS_COMMIT, 32'h1);
        rd_chk(rcs_pkg::OFS_COMMIT, 32'h0);
        wr(rcs_pkg::OFS_STATUS, 32'h2);
        u_host.write_time(tm);
        wr(rcs_pkg::OFS_COMMIT, 32'h1);
        rd_chk(rcs_pkg::OFS_COMMIT, 32'h1ff);
        rd_chk(rcs_pkg::OFS_TIME, 32'h0);
        wr(rcs_pkg::OFS_ALARM, 32'h85);
        rd_chk(rcs_pkg::OFS_ALARM, 32'h85);
        for (int f = 0; f < 4; f++) begin
            wr(rcs_pkg::OFS_CONTROL, 32'(f));
            c = 0;
            repeat (512) begin
                p = irq_oe;
                @(posedge clk);
                if (irq_oe !== p) c++;
            end
            check_val(c >= fq_t[f] - 2 && c <= fq_t[f] + 2, 32'h1);
        end
        for (int w = 1; w < 4; w++) begin
            wr(rcs_pkg::OFS_CONTROL, 32'(w) << 7);
            wr(rcs_pkg::OFS_KICK, 32'h0);
            wait_oe(1'b1, c);
            check_val(c >= wd_t[w] - 6 && c <= wd_t[w] + 2, 32'h1);
            rd_chk(rcs_pkg::OFS_STATUS, 32'h0);
            wait_oe(1'b0, c);
        end
        wr(rcs_pkg::OFS_CONTROL, 32'h240);
        repeat (200) @(posedge clk);
        check_val(rst_oe, 32'h0);
        sup <= 5'h0f;
        wait_oe(1'b1, c);
        check_val(c <= 6, 32'h1);
        bat <= 1'b1;
        sup <= 5'h00;
        repeat (5) @(posedge clk);
        sup <= 5'h1f;
        repeat (150) @(posedge clk);
        rd_chk(rcs_pkg::OFS_STATUS, 32'h82);
        check_val(rst_oe, 32'h1);
        bat <= 1'b0;
        wait_oe(1'b0, c);
        check_val(c >= 48 && c <= 58, 32'h1);
        final_report();
    end
endmodule
`default_nettype wire
